//--- verilog/amtor_mode_controller.v
// amtor mode controller: terminal directive interpreter and role sequencer
// assumes apb master on pclk; modem and coder sit outside and report events
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "amtor_mode_defines.vh"
module amtor_mode_controller
#(
   parameter REQ_CYCLES = `LINK_REQ_NS / `CLK_NS,
   parameter MIN_CYCLES = `ID_MINUTE_CYCLES
)
(
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // transmitter and indicators
   output reg tx_key,
   output reg bargraph_on,
   output reg tx_lamp,
   // link coder requests, one-cycle pulses
   output reg send_changeover,
   output reg send_shutdown,
   output reg send_link_req,
   output reg send_preamble,
   output reg send_who,
   output reg send_morse_id,
   output reg rx_resync,
   output reg tx_flush,
   // demodulator and afsk sense, trace
   output reg rx_invert,
   output reg tx_invert,
   output reg trace_on
);

   localparam S_CMD = 3'd0;
   localparam S_STBY = 3'd1;
   localparam S_CALL = 3'd2;
   localparam S_ISS = 3'd3;
   localparam S_IRS = 3'd4;
   localparam S_FEC = 3'd5;
   localparam S_LISTEN = 3'd6;

   function is_addr;
      input [11:0] a;
      input [11:0] r;
      begin
         is_addr = (a == r);
      end
   endfunction

   function is_linked;
      input [2:0] s;
      begin
         is_linked = (s == S_ISS) || (s == S_IRS);
      end
   endfunction

   // listen-only never keys, whatever the role says
   function keys_tx;
      input [2:0] s;
      input t;
      begin
         keys_tx = (s != S_LISTEN) && (t || s == S_ISS || s == S_CALL);
      end
   endfunction

   reg [2:0] state_q;
   reg tx_q;
   reg drain_q;
   reg selfec_q;
   reg prefix_q;
   reg standby_msg_q;
   reg linked_msg_q;
   reg [7:0] cfg_idmin_q;
   reg [7:0] cfg_speed_q;
   reg [7:0] cfg_text_q;
   reg cfg_auto_q;
   reg cfg_afsk_q;
   reg [27:0] own_code_q;
   reg [27:0] dest_code_q;
   reg [7:0] rx_char_q;
   reg rx_pass_q;
   reg [7:0] last_char_q;
   reg [31:0] req_cnt_q;
   reg [31:0] cyc_cnt_q;
   reg [7:0] min_cnt_q;

   wire wr = psel & penable & pwrite;
   wire rd_acc = psel & penable & ~pwrite;
   wire ch_wr = wr & is_addr(paddr, `REG_TXDATA);
   wire [7:0] ch = pwdata[7:0];
   wire dir = ch_wr & prefix_q;
   wire plain = ch_wr & ~prefix_q & (ch != `CH_CTRL_C);
   wire ev_wr = wr & is_addr(paddr, `REG_EVENT);
   wire cmd_wr = wr & is_addr(paddr, `REG_CMD);
   wire [5:0] ev = ev_wr ? pwdata[5:0] : 6'h00;
   // unmapped words answer with an error, never with wait states
   wire mapped = is_addr(paddr, `REG_CMD) | is_addr(paddr, `REG_CFG) |
      is_addr(paddr, `REG_STATUS) | is_addr(paddr, `REG_TXDATA) |
      is_addr(paddr, `REG_RXDATA) | is_addr(paddr, `REG_SELCAL) |
      is_addr(paddr, `REG_EVENT);
   wire typed_co = plain & (last_char_q == `CH_PLUS) & (ch == `CH_QMARK);
   wire id_due = is_linked(state_q) &&
      (cfg_idmin_q != 8'h00) && (min_cnt_q >= cfg_idmin_q);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= S_CMD;
         tx_q <= 1'b0;
         drain_q <= 1'b0;
         selfec_q <= 1'b0;
         prefix_q <= 1'b0;
         standby_msg_q <= 1'b0;
         linked_msg_q <= 1'b0;
         cfg_idmin_q <= 8'h00;
         cfg_speed_q <= 8'h00;
         cfg_text_q <= 8'h00;
         cfg_auto_q <= 1'b0;
         cfg_afsk_q <= 1'b0;
         own_code_q <= 28'h0000000;
         dest_code_q <= 28'h0000000;
         rx_char_q <= 8'h00;
         rx_pass_q <= 1'b0;
         last_char_q <= 8'h00;
         req_cnt_q <= 32'h00000000;
         cyc_cnt_q <= 32'h00000000;
         min_cnt_q <= 8'h00;
         tx_key <= 1'b0;
         bargraph_on <= 1'b1;
         tx_lamp <= 1'b0;
         send_changeover <= 1'b0;
         send_shutdown <= 1'b0;
         send_link_req <= 1'b0;
         send_preamble <= 1'b0;
         send_who <= 1'b0;
         send_morse_id <= 1'b0;
         rx_resync <= 1'b0;
         tx_flush <= 1'b0;
         rx_invert <= 1'b0;
         tx_invert <= 1'b0;
         trace_on <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         send_changeover <= 1'b0;
         send_shutdown <= 1'b0;
         send_link_req <= 1'b0;
         send_preamble <= 1'b0;
         send_who <= 1'b0;
         send_morse_id <= 1'b0;
         rx_resync <= 1'b0;
         tx_flush <= 1'b0;
         // zero-wait slave; error only on unmapped words
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel & ~penable)
         begin
            case (paddr)
               `REG_CMD: prdata <= {dest_code_q, 4'h0};
               `REG_CFG: prdata <= {cfg_text_q, cfg_speed_q, cfg_idmin_q,
                  6'h00, cfg_afsk_q, cfg_auto_q};
               `REG_STATUS: prdata <= {23'h000000, linked_msg_q,
                  standby_msg_q, trace_on, selfec_q, drain_q, tx_q, state_q};
               `REG_RXDATA: prdata <= {23'h000000, rx_pass_q, rx_char_q};
               `REG_SELCAL: prdata <= {4'h0, own_code_q};
               default: prdata <= 32'h00000000;
            endcase
         end
         // status flags: set wins over read-clear
         if (rd_acc & is_addr(paddr, `REG_STATUS))
         begin
            standby_msg_q <= 1'b0;
            linked_msg_q <= 1'b0;
         end
         if (wr & is_addr(paddr, `REG_CFG))
         begin
            cfg_auto_q <= pwdata[`CFG_AUTO_BIT];
            cfg_afsk_q <= pwdata[`CFG_AFSK_BIT];
            cfg_idmin_q <= pwdata[`CFG_IDMIN_LSB+7:`CFG_IDMIN_LSB];
            cfg_speed_q <= pwdata[`CFG_SPEED_LSB+7:`CFG_SPEED_LSB];
            cfg_text_q <= pwdata[`CFG_TEXT_LSB+7:`CFG_TEXT_LSB];
         end
         if (wr & is_addr(paddr, `REG_SELCAL))
            own_code_q <= pwdata[27:0];
         // control-c arms; next char is the directive
         if (ch_wr)
            prefix_q <= ~prefix_q & (ch == `CH_CTRL_C);
         if (plain)
            last_char_q <= ch;
         // morse id minute timer while linked
         if (is_linked(state_q))
         begin
            if (cyc_cnt_q >= MIN_CYCLES - 1)
            begin
               cyc_cnt_q <= 32'h00000000;
               min_cnt_q <= min_cnt_q + 8'h01;
            end
            else
               cyc_cnt_q <= cyc_cnt_q + 32'h00000001;
         end
         else
         begin
            cyc_cnt_q <= 32'h00000000;
            min_cnt_q <= 8'h00;
         end
         if (id_due)
         begin
            send_morse_id <= 1'b1;
            min_cnt_q <= 8'h00;
            cyc_cnt_q <= 32'h00000000;
         end
         // received broadcast filter
         if (ev[`EV_SELFEC_START] | ev[`EV_FEC_START])
         begin
            rx_char_q <= pwdata[15:8];
            if (state_q == S_LISTEN)
               rx_pass_q <= 1'b1;
            else if (cfg_auto_q && !selfec_q &&
               (state_q == S_STBY || state_q == S_FEC))
               rx_pass_q <= ev[`EV_SELFEC_START] &
                  (pwdata[27:16] == own_code_q[11:0]);
            else
               rx_pass_q <= 1'b1;
         end
         if (ev[`EV_SELFEC_START] == 1'b0 && ev[`EV_FEC_START] == 1'b0 &&
            ev_wr && (state_q == S_IRS || state_q == S_LISTEN))
         begin
            rx_char_q <= pwdata[15:8];
            rx_pass_q <= 1'b1;
         end
         // mode-independent directives; who-are-you key only as sending station
         if (dir && ch == "I")
         begin
            rx_invert <= ~rx_invert;
            tx_invert <= cfg_afsk_q ? ~tx_invert : tx_invert;
         end
         if (dir && ch == `CH_CTRL_T)
            trace_on <= ~trace_on;
         if (plain && ch == `CH_CTRL_W && state_q == S_ISS)
            send_who <= 1'b1;
         // exit drops queued text; the coder empties its buffer on tx_flush
         if (dir && ch == "X" && state_q != S_CMD)
         begin
            state_q <= S_CMD;
            tx_flush <= 1'b1;
            tx_q <= 1'b0;
            drain_q <= 1'b0;
            selfec_q <= 1'b0;
         end
         else if (cmd_wr)
         begin
            tx_q <= 1'b0;
            drain_q <= 1'b0;
            selfec_q <= 1'b0;
            case (pwdata[2:0])
               `CMD_STANDBY:
               begin
                  state_q <= S_STBY;
                  standby_msg_q <= 1'b1;
               end
               `CMD_CALL:
               begin
                  state_q <= S_CALL;
                  dest_code_q <= pwdata[31:4];
                  req_cnt_q <= 32'h00000000;
               end
               `CMD_FEC:
                  state_q <= S_FEC;
               `CMD_SELFEC:
               begin
                  state_q <= S_FEC;
                  selfec_q <= 1'b1;
                  dest_code_q <= pwdata[31:4];
                  tx_q <= 1'b1;
                  send_preamble <= 1'b1;
               end
               `CMD_LISTEN:
                  state_q <= S_LISTEN;
               default:
                  state_q <= state_q;
            endcase
         end
         else
         begin
            case (state_q)
               S_STBY, S_FEC:
               begin
                  if (dir && ch == "T")
                  begin
                     tx_q <= 1'b1;
                     drain_q <= 1'b0;
                     send_preamble <= selfec_q;
                  end
                  if (dir && ch == "E" && tx_q)
                     drain_q <= 1'b1;
                  // receive-now keeps the buffer: no flush here
                  if (dir && ch == "R" && tx_q)
                  begin
                     tx_q <= 1'b0;
                     drain_q <= 1'b0;
                  end
                  if (drain_q && ev[`EV_TX_DONE])
                  begin
                     tx_q <= 1'b0;
                     drain_q <= 1'b0;
                     if (state_q == S_STBY)
                        standby_msg_q <= 1'b1;
                  end
                  if (state_q == S_STBY && ev[`EV_LINK_REQ] && !tx_q)
                  begin
                     state_q <= S_IRS;
                     linked_msg_q <= 1'b1;
                  end
               end
               S_CALL:
               begin
                  // repeat the request until the far end acknowledges
                  if (req_cnt_q == 32'h00000000)
                     send_link_req <= 1'b1;
                  req_cnt_q <= (req_cnt_q >= REQ_CYCLES - 1) ?
                     32'h00000000 : req_cnt_q + 32'h00000001;
                  if (ev[`EV_ACK])
                  begin
                     state_q <= S_ISS;
                     linked_msg_q <= 1'b1;
                  end
               end
               S_IRS:
               begin
                  if (ev[`EV_CHANGEOVER])
                     state_q <= S_ISS;
                  if (dir && ch == "T")
                     state_q <= S_ISS;
               end
               S_ISS:
               begin
                  if (typed_co || (dir && ch == "R"))
                  begin
                     send_changeover <= 1'b1;
                     state_q <= S_IRS;
                  end
               end
               S_LISTEN:
               begin
                  if (dir && ch == "R")
                     rx_resync <= 1'b1;
               end
               default:
                  state_q <= state_q;
            endcase
            if (is_linked(state_q) && dir &&
               (ch == "D" || ch == "A"))
            begin
               send_shutdown <= 1'b1;
               state_q <= S_STBY;
               standby_msg_q <= 1'b1;
               send_morse_id <= (cfg_idmin_q != 8'h00);
            end
         end
         // keying follows role; listen-only can never key
         tx_key <= keys_tx(state_q, tx_q);
         tx_lamp <= keys_tx(state_q, tx_q);
         bargraph_on <= ~keys_tx(state_q, tx_q);
      end
   end

endmodule

//--- verilog/amtor_mode_defines.vh
// constants for the amtor mode controller: register offsets, fields, codes
// assumes an apb slave with 32-bit data, one register per aligned word
// Functional notes
// - enter-transmit in standby keys, darkens bargraph, lights tx lamp
// - end-transmit in standby drains buffer, returns standby, reports it
// - remote link makes us receiving station; received data to terminal
// - received changeover makes us sending station after display
// - typed changeover as sender is sent; we become receiver
// - break-link sends shutdown, stops in standby, morse id if interval set
// - mode command with code sends link requests, acknowledged makes sender
// - enter-transmit while receiver seizes sending role immediately
// - broadcast mode entered silently; receives or transmits broadcasts
// - end-transmit in broadcast drains buffer then returns to receive
// - addressed-copy-only in standby and plain broadcast passes only selective broadcasts with our code
// - selective broadcast sends destination preamble on every transmission
// - selective broadcast drain unkeys and accepts any broadcast
// - listen-only displays all traffic and never keys transmitter
// - receive-now while monitoring resynchronises receiver
// - linked: morse id every interval minutes with set text and speed
// - invert swaps demodulator sense and afsk transmit sense
// - receive-now ends broadcast keeping buffer; linked inserts changeover
// - trace-toggle flips trace option each time
// - who-are-you key transmits identify request
// - exit discards transmit buffer and returns to command state
`ifndef AMTOR_MODE_DEFINES_VH
`define AMTOR_MODE_DEFINES_VH
// register byte offsets
`define REG_CMD 12'h000
`define REG_CFG 12'h004
`define REG_STATUS 12'h008
`define REG_TXDATA 12'h00c
`define REG_RXDATA 12'h010
`define REG_SELCAL 12'h014
`define REG_EVENT 12'h018
// command register codes (software issues mode commands)
`define CMD_STANDBY 3'h1
`define CMD_CALL 3'h2
`define CMD_FEC 3'h3
`define CMD_SELFEC 3'h4
`define CMD_LISTEN 3'h5
// cfg fields
`define CFG_AUTO_BIT 0
`define CFG_AFSK_BIT 1
`define CFG_IDMIN_LSB 8
`define CFG_SPEED_LSB 16
`define CFG_TEXT_LSB 24
// link events from remote side and tx done from coder (event register bits)
`define EV_LINK_REQ 0
`define EV_CHANGEOVER 1
`define EV_ACK 2
`define EV_SELFEC_START 3
`define EV_FEC_START 4
`define EV_TX_DONE 5
// terminal characters
`define CH_CTRL_C 8'h03
`define CH_CTRL_T 8'h14
`define CH_CTRL_W 8'h17
`define CH_PLUS 8'h2b
`define CH_QMARK 8'h3f
// link request repeat
`define LINK_REQ_NS 450000000
`define CLK_NS 25
// one minute of pclk for the morse id timer
`define ID_MINUTE_CYCLES 32'd2400000000
`endif

//--- bench/amtor_mode_sva.sv
// checker: apb handshake and transmitter relations at the controller ports
// assumes a bind from the bench top; presetn is async, active low
`timescale 1ns/1ps
module amtor_mode_sva
#(
   parameter REQ_CYCLES = 20,
   parameter MIN_CYCLES = 50
)
(
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // transmitter and indicators
   input wire tx_key,
   input wire bargraph_on,
   input wire tx_lamp,
   // coder pulses
   input wire send_changeover,
   input wire send_shutdown,
   input wire send_link_req,
   input wire send_preamble,
   input wire send_who,
   input wire send_morse_id,
   input wire rx_resync,
   input wire tx_flush,
   // sense and trace
   input wire rx_invert,
   input wire tx_invert,
   input wire trace_on
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_KEY_LAMP: assert property (tx_key == tx_lamp)
      else $error("lamp differs from key");
   AST_KEY_DARK: assert property (tx_key != bargraph_on)
      else $error("bargraph lit while keyed");
   AST_ACCESS_READY: assert property (psel && penable |-> pready)
      else $error("no ready in access cycle");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_READY: assert property (pslverr |-> pready && psel && penable)
      else $error("error outside access");
   AST_RDATA_HOLD: assert property (!psel |=> $stable(prdata))
      else $error("read data moved while idle");
   AST_SHUT_PULSE: assert property (send_shutdown |=> !send_shutdown)
      else $error("shutdown pulse too long");
   AST_CO_PULSE: assert property (send_changeover |=> !send_changeover)
      else $error("changeover pulse too long");
   AST_REQ_GAP: assert property (send_link_req |=> !send_link_req [*8])
      else $error("link requests too close");
   AST_FLUSH_UNKEY: assert property (tx_flush |-> ##[0:3] !tx_key)
      else $error("still keyed after exit");
endmodule

//--- bench/remote_station.sv
// partner: remote station that acknowledges after ACK_AFTER link requests
// assumes the bench turns ack_due into an event register write
`timescale 1ns/1ps
module remote_station
#(
   parameter ACK_AFTER = 2
)
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // from the controller
   input wire send_link_req,
   input wire send_changeover,
   // to the bench
   output reg ack_due,
   output reg co_seen
);
   reg [3:0] req_q;
   // a real station needs repeated requests before it answers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_q <= 4'h0;
         ack_due <= 1'b0;
         co_seen <= 1'b0;
      end
      else
      begin
         if (send_link_req)
            req_q <= req_q + 4'h1;
         ack_due <= (req_q >= ACK_AFTER);
         if (send_changeover)
            co_seen <= 1'b1;
      end
   end
endmodule

//--- bench/amtor_mode_controller_tb_top.sv
// bench top: apb master, pulse counters, expected state and checks
// assumes shortened minute and request counts through parameters
`timescale 1ns/1ps
`include "amtor_mode_defines.vh"
module amtor_mode_controller_tb_top;
   reg pclk;
   reg presetn;
   reg psel;
   reg penable;
   reg pwrite;
   reg [11:0] paddr;
   reg [31:0] pwdata;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire tx_key;
   wire bargraph_on;
   wire tx_lamp;
   wire [7:0] p;
   wire rx_invert;
   wire tx_invert;
   wire trace_on;
   wire ack_due;
   wire co_seen;
   integer err_total;
   integer checked;
   integer cnt [0:7];
   integer k;
   integer j;
   integer m;
   reg [31:0] rd;
   reg rerr;
   amtor_mode_controller #(.REQ_CYCLES(20), .MIN_CYCLES(50)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_key(tx_key),
      .bargraph_on(bargraph_on), .tx_lamp(tx_lamp),
      .send_changeover(p[0]), .send_shutdown(p[1]), .send_link_req(p[2]),
      .send_preamble(p[3]), .send_who(p[4]), .send_morse_id(p[5]),
      .rx_resync(p[6]), .tx_flush(p[7]), .rx_invert(rx_invert),
      .tx_invert(tx_invert), .trace_on(trace_on));
   remote_station #(.ACK_AFTER(2)) far (.pclk(pclk), .presetn(presetn),
      .send_link_req(p[2]), .send_changeover(p[0]), .ack_due(ack_due),
      .co_seen(co_seen));
   always @(posedge pclk)
   begin
      for (j = 0; j < 8; j = j + 1)
         cnt[j] <= presetn ? cnt[j] + p[j] : 0;
   end
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task give_verdict;
      begin
         $display("checks %0d errors %0d", checked, err_total);
         if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input reg [31:0] got, input reg [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            err_total = err_total + 1;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // every transfer is followed by idle cycles so effects have landed
   task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 50)
         begin
            n = n + 1;
            @(posedge pclk);
         end
         if (n >= 50)
            chk(pready, 1);
         rd = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask
   task dir(input reg [7:0] c);
      begin
         apb(1'b1, `REG_TXDATA, {24'h0, `CH_CTRL_C});
         apb(1'b1, `REG_TXDATA, {24'h0, c});
      end
   endtask
   task st(input reg [31:0] msk, input reg [31:0] e);
      begin
         apb(1'b0, `REG_STATUS, 32'h0);
         chk(rd & msk, e);
      end
   endtask
   task rxev(input reg [31:0] e, input reg [31:0] x);
      begin
         apb(1'b1, `REG_EVENT, e);
         apb(1'b0, `REG_RXDATA, 32'h0);
         chk(rd, x);
      end
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total = err_total + 1;
      give_verdict;
   end
   initial
   begin
      err_total = 0;
      checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      m = $urandom(32'h55a71da8);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk(bargraph_on, 1);
      st(32'h1ff, 0);
      apb(1'b0, 12'h01c, 32'h0);
      chk(rerr, 1);
      chk(rd, 0);
      apb(1'b1, `REG_CFG, 32'h2);
      apb(1'b1, `REG_CMD, `CMD_STANDBY);
      dir(8'h54);
      chk({tx_key, bargraph_on}, 2'b10);
      st(32'h18f, 32'h89);
      dir(8'h45);
      apb(1'b1, `REG_EVENT, 32'h20);
      st(32'h18f, 32'h81);
      st(32'h18f, 32'h1);
      apb(1'b1, `REG_EVENT, 32'h1);
      st(7, 4);
      rxev(32'h4d00, 32'h14d);
      apb(1'b1, `REG_EVENT, 32'h2);
      st(7, 3);
      apb(1'b1, `REG_TXDATA, {24'h0, `CH_PLUS});
      apb(1'b1, `REG_TXDATA, {24'h0, `CH_QMARK});
      chk(cnt[0], 1);
      chk(co_seen, 1);
      st(7, 4);
      dir(8'h54);
      st(7, 3);
      for (k = 0; k < 4; k = k + 1)
         apb(1'b1, `REG_TXDATA, $urandom_range(32'h5a, 32'h41));
      apb(1'b1, `REG_TXDATA, {24'h0, `CH_CTRL_W});
      chk(cnt[4], 1);
      dir(8'h52);
      chk(cnt[0], 2);
      dir(8'h44);
      chk(cnt[1], 1);
      chk(cnt[5], 0);
      st(7, 1);
      apb(1'b1, `REG_CFG, 32'h102);
      apb(1'b1, `REG_EVENT, 32'h1);
      repeat (120) @(posedge pclk);
      m = cnt[5];
      chk(m > 0, 1);
      dir(8'h44);
      repeat (20) @(posedge pclk);
      chk(cnt[5] > m, 1);
      dir(8'h58);
      chk(cnt[7], 1);
      st(7, 0);
      apb(1'b1, `REG_CMD, 32'h1232);
      st(7, 2);
      apb(1'b0, `REG_CMD, 32'h0);
      chk(rd, 32'h1230);
      for (k = 0; k < 300 && ack_due !== 1'b1; k = k + 1)
         @(posedge pclk);
      chk(ack_due, 1);
      apb(1'b1, `REG_EVENT, 32'h4);
      st(32'h107, 32'h103);
      dir(8'h58);
      apb(1'b1, `REG_CMD, `CMD_FEC);
      st(32'h1ff, 5);
      dir(8'h54);
      chk(tx_key, 1);
      dir(8'h45);
      apb(1'b1, `REG_EVENT, 32'h20);
      chk(tx_key, 0);
      st(7, 5);
      dir(8'h54);
      dir(8'h52);
      chk(tx_key, 0);
      chk(cnt[7], 2);
      dir(8'h03);
      apb(1'b1, `REG_TXDATA, {24'h0, 8'h54});
      chk(tx_key, 0);
      dir(8'h58);
      apb(1'b1, `REG_CMD, 32'h4564);
      chk(cnt[3], 1);
      chk(tx_key, 1);
      apb(1'b0, `REG_CMD, 32'h0);
      chk(rd, 32'h4560);
      dir(8'h45);
      apb(1'b1, `REG_EVENT, 32'h20);
      chk(tx_key, 0);
      apb(1'b1, `REG_CFG, 32'h2c0f0003);
      apb(1'b0, `REG_CFG, 32'h0);
      chk(rd, 32'h2c0f0003);
      rxev(32'h4410, 32'h144);
      dir(8'h54);
      chk(cnt[3], 2);
      dir(8'h58);
      apb(1'b1, `REG_CMD, `CMD_LISTEN);
      st(7, 6);
      dir(8'h54);
      chk(tx_key, 0);
      dir(8'h52);
      chk(cnt[6], 1);
      rxev(32'h01234208, 32'h142);
      dir(8'h49);
      chk({rx_invert, tx_invert}, 3);
      dir(`CH_CTRL_T);
      chk(trace_on, 1);
      dir(`CH_CTRL_T);
      chk(trace_on, 0);
      dir(8'h58);
      apb(1'b1, `REG_CMD, 32'h1);
      apb(1'b1, `REG_SELCAL, 32'habc);
      apb(1'b0, `REG_SELCAL, 32'h0);
      chk(rd, 32'habc);
      rxev(32'h0abc4108, 32'h141);
      rxev(32'h01234208, 32'h042);
      rxev(32'h4310, 32'h043);
      give_verdict;
   end
endmodule
bind amtor_mode_controller amtor_mode_sva #(.REQ_CYCLES(REQ_CYCLES),
   .MIN_CYCLES(MIN_CYCLES)) chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_key(tx_key), .bargraph_on(bargraph_on), .tx_lamp(tx_lamp),
   .send_changeover(send_changeover), .send_shutdown(send_shutdown),
   .send_link_req(send_link_req), .send_preamble(send_preamble),
   .send_who(send_who), .send_morse_id(send_morse_id),
   .rx_resync(rx_resync), .tx_flush(tx_flush), .rx_invert(rx_invert),
   .tx_invert(tx_invert), .trace_on(trace_on));
